// ===== include/fesq_pkg.sv
// Constants shared by the flash erase command sequencer files
package fesq_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_NS       = 10;
    localparam int unsigned T_WP_NS      = 35;   // Write strobe low time
    localparam int unsigned T_ACC_NS     = 90;   // Read access time
    localparam int unsigned T_RP_NS      = 500;  // Hardware reset pulse
    localparam int unsigned SECT_WIN_US  = 50;   // Sector load window
    localparam int unsigned WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RP_CYC  = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SECT_WIN_CYC = SECT_WIN_US * 1000 / CLK_NS;
    // Cycles from a request to the falling strobe of the next load
    localparam int unsigned WIN_MARGIN   = 4;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RDATA  = 8'h0c;
    localparam int unsigned ST_BUSY    = 0;
    localparam int unsigned ST_DONE    = 1;
    localparam int unsigned ST_REFUSED = 2;
    localparam int unsigned ST_RDY     = 3;
    localparam int unsigned ST_WINDOW  = 4;
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [21:0] ADDR_RST   = 22'h000000;

    // ****************************************************************
    // Operations written to the control register
    // ****************************************************************
    localparam logic [3:0] OP_CHIP   = 4'h1;
    localparam logic [3:0] OP_SECT   = 4'h2;
    localparam logic [3:0] OP_ADD    = 4'h3;
    localparam logic [3:0] OP_SUSP   = 4'h4;
    localparam logic [3:0] OP_RESUME = 4'h5;
    localparam logic [3:0] OP_ID     = 4'h6;
    localparam logic [3:0] OP_QUERY  = 4'h7;
    localparam logic [3:0] OP_EXIT   = 4'h8;
    localparam logic [3:0] OP_READ   = 4'h9;
    localparam logic [3:0] OP_POLL   = 4'ha;
    localparam logic [3:0] OP_HWRST  = 4'hb;

    // ****************************************************************
    // Flash command codes and unlock addresses
    // ****************************************************************
    localparam logic [21:0] UNLOCK1_ADDR = 22'h000555;
    localparam logic [21:0] UNLOCK2_ADDR = 22'h0002aa;
    localparam logic [21:0] QUERY_ADDR   = 22'h000055;
    localparam logic [15:0] CMD_UNLOCK1  = 16'h00aa;
    localparam logic [15:0] CMD_UNLOCK2  = 16'h0055;
    localparam logic [15:0] CMD_SETUP    = 16'h0080;
    localparam logic [15:0] CMD_CHIP     = 16'h0010;
    localparam logic [15:0] CMD_SECT     = 16'h0030;
    localparam logic [15:0] CMD_SUSP     = 16'h00b0;
    localparam logic [15:0] CMD_RESUME   = 16'h0030;
    localparam logic [15:0] CMD_ID       = 16'h0090;
    localparam logic [15:0] CMD_QUERY    = 16'h0098;
    localparam logic [15:0] CMD_RESET    = 16'h00f0;
    localparam int unsigned POLL_BIT     = 7;
    localparam int unsigned TOGGLE_BIT   = 6;

endpackage : fesq_pkg

// ===== hw/fesq_bus_cycle.sv
// One timed write or read cycle on the flash parallel pins
`timescale 1ns/1ps
`default_nettype none

module fesq_bus_cycle (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Request
    input  wire logic        start,
    input  wire logic        is_write,
    input  wire logic [21:0] addr,
    input  wire logic [15:0] wdata,
    output logic             done,
    output logic [15:0]      rdata,
    // Flash pins
    output logic [21:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_we_n,
    output logic             flash_oe_n
);

    typedef enum logic [3:0] {
        C_IDLE = 4'b0001,
        C_SET  = 4'b0010,
        C_STB  = 4'b0100,
        C_HOLD = 4'b1000
    } fesq_cyc_t;

    fesq_cyc_t  state;
    logic [3:0] cnt;
    logic       wr;
    logic [3:0] stb_len;
    assign stb_len = wr ? 4'(fesq_pkg::WP_CYC) : 4'(fesq_pkg::ACC_CYC);

    // ****************************************************************
    // Strobe sequencing
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= C_IDLE;
            cnt          <= 4'h0;
            wr           <= 1'b0;
            done         <= 1'b0;
            rdata        <= 16'h0000;
            flash_addr   <= 22'h000000;
            flash_dq_out <= 16'h0000;
            flash_dq_oe  <= 1'b0;
            flash_ce_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state)
                C_IDLE: begin
                    if (start) begin
                        wr           <= is_write;
                        flash_addr   <= addr;
                        flash_dq_out <= wdata;
                        flash_dq_oe  <= is_write;
                        flash_ce_n   <= 1'b0;
                        state        <= C_SET;
                    end
                end
                C_SET: begin
                    // Address is settled a cycle before the strobe falls
                    flash_we_n <= ~wr;
                    flash_oe_n <= wr;
                    cnt        <= 4'h1;
                    state      <= C_STB;
                end
                C_STB: begin
                    if (cnt >= stb_len) begin
                        if (!wr) begin
                            rdata <= flash_dq_in;
                        end
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        state      <= C_HOLD;
                    end else begin
                        cnt <= cnt + 4'h1;
                    end
                end
                C_HOLD: begin
                    // Data held one cycle past the rising strobe
                    flash_ce_n  <= 1'b1;
                    flash_dq_oe <= 1'b0;
                    done        <= 1'b1;
                    state       <= C_IDLE;
                end
                default: begin
                    state <= C_IDLE;
                end
            endcase
        end
    end

endmodule : fesq_bus_cycle

`default_nettype wire

// ===== hw/fesq_poll.sv
// Erase completion check on the polling and toggle bits
`timescale 1ns/1ps
`default_nettype none

module fesq_poll (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Samples
    input  wire logic clear,
    input  wire logic sample,
    input  wire logic poll_bit,
    input  wire logic toggle_bit,
    // Result
    output logic      finished
);

    logic have_prev;
    logic prev_toggle;

    // ****************************************************************
    // Two consecutive reads compared
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            have_prev   <= 1'b0;
            prev_toggle <= 1'b0;
            finished    <= 1'b0;
        end else if (clear) begin
            have_prev <= 1'b0;
            finished  <= 1'b0;
        end else if (sample) begin
            have_prev   <= 1'b1;
            prev_toggle <= toggle_bit;
            finished    <= have_prev && poll_bit &&
                           (prev_toggle == toggle_bit); // see [RQ8]
        end
    end

endmodule : fesq_poll

`default_nettype wire

// ===== hw/fesq_ctrl.sv
// Host controller issuing erase, suspend, ID and query sequences
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RQ1] Chip erase: unlock, 80H, unlock, 10H
// [RQ2] Sector erase: same, last write 30H
// [RQ3] ID read with low bits zero: maker
// [RQ4] Device preprograms before erase by itself
// [RQ5] Device ignores commands while erasing, bar suspend
// [RQ6] Hardware reset aborts; erase reissued afterwards
// [RQ7] Device returns to array read after erase
// [RQ8] Done: polling 1, toggle steady twice
// [RQ9] Address at late fall, data early rise
// [RQ10] Sector latched on sixth falling strobe
// [RQ11] Extra sector load within 50us
// [RQ12] Other command in window: back to read
// [RQ13] Suspend honoured only during sector erase
// [RQ14] Suspend halts erase within 20us
// [RQ15] Suspend in window ends it at once
// [RQ16] Suspended: resume, program, unselected reads only
// [RQ17] Suspend program reports status on bits
// [RQ18] Resume acts only after accepted suspend
// [RQ19] Suspend and resume may repeat
// [RQ20] Query entered only from read-like states
// [RQ21] Reset in query returns to prior state
// [RQ22] Query offsets 10-12 give QRY
// [RQ23] ID read at 01h gives device code
// [RQ24] ID read at 02h gives protection
// [RQ25] ID mode left by reset command
// [RQ26] Wrong unlock pattern drops the sequence
// [RQ27] Ready/busy shows busy while erasing
module fesq_ctrl #(
    parameter int unsigned WIN_CYC = fesq_pkg::SECT_WIN_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Flash pins
    output logic [21:0]      flash_addr,
    output logic [15:0]      flash_dq_out,
    output logic             flash_dq_oe,
    input  wire logic [15:0] flash_dq_in,
    output logic             flash_ce_n,
    output logic             flash_we_n,
    output logic             flash_oe_n,
    output logic             flash_reset_n,
    input  wire logic        ready_busy_n
);

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_ISSUE = 6'b000010,
        S_WAIT  = 6'b000100,
        S_PCHK  = 6'b001000,
        S_RST   = 6'b010000,
        S_RWAIT = 6'b100000
    } fesq_state_t;

    fesq_state_t  state;
    logic [3:0]   op;
    logic [21:0]  addr;
    logic [2:0]   idx;
    logic         done_flag;
    logic         refused;
    logic [15:0]  rdata;
    logic         win_open;
    logic [12:0]  win_cnt;
    logic [7:0]   rst_cnt;
    logic [39:0]  step;
    logic         cyc_start;
    logic         cyc_done;
    logic [15:0]  cyc_rdata;
    logic         poll_done;
    logic         apb_wr;
    logic         ctrl_wr;
    logic         op_valid;
    logic         win_late;
    logic         accept;
    logic         reject;
    logic         last_step;
    logic         mapped;

    // ****************************************************************
    // Command scripts
    // ****************************************************************
    // Returns {last, write, address, data} of one step of an operation
    function automatic logic [39:0] fesq_step(
        input logic [3:0]  o,
        input logic [2:0]  i,
        input logic [21:0] sa
    );
        logic [21:0] a;
        logic [15:0] d;
        logic        w;
        logic        l;
        a = fesq_pkg::UNLOCK1_ADDR;
        d = fesq_pkg::CMD_UNLOCK1;
        w = 1'b1;
        l = 1'b0;
        case (o)
            fesq_pkg::OP_CHIP, fesq_pkg::OP_SECT: begin
                case (i)
                    3'd0, 3'd3: begin
                    end
                    3'd1, 3'd4: begin
                        a = fesq_pkg::UNLOCK2_ADDR;
                        d = fesq_pkg::CMD_UNLOCK2;
                    end
                    3'd2: begin
                        d = fesq_pkg::CMD_SETUP;
                    end
                    default: begin
                        l = 1'b1;
                        if (o == fesq_pkg::OP_CHIP) begin
                            d = fesq_pkg::CMD_CHIP; // see [RQ1]
                        end else begin
                            a = sa;
                            d = fesq_pkg::CMD_SECT; // see [RQ2]
                        end
                    end
                endcase
            end
            fesq_pkg::OP_ID: begin
                if (i == 3'd1) begin
                    a = fesq_pkg::UNLOCK2_ADDR;
                    d = fesq_pkg::CMD_UNLOCK2;
                end else if (i == 3'd2) begin
                    l = 1'b1;
                    d = fesq_pkg::CMD_ID;
                end
            end
            fesq_pkg::OP_ADD: begin
                l = 1'b1;
                a = sa;
                d = fesq_pkg::CMD_SECT; // see [RQ11]
            end
            fesq_pkg::OP_SUSP: begin
                l = 1'b1;
                d = fesq_pkg::CMD_SUSP;
            end
            fesq_pkg::OP_RESUME: begin
                l = 1'b1;
                d = fesq_pkg::CMD_RESUME;
            end
            fesq_pkg::OP_QUERY: begin
                l = 1'b1;
                a = fesq_pkg::QUERY_ADDR;
                d = fesq_pkg::CMD_QUERY;
            end
            fesq_pkg::OP_EXIT: begin
                l = 1'b1;
                d = fesq_pkg::CMD_RESET; // see [RQ25]
            end
            default: begin
                l = 1'b1;
                w = 1'b0;
                a = sa;
            end
        endcase
        return {l, w, a, d};
    endfunction : fesq_step

    assign step      = fesq_step(op, idx, addr);
    assign last_step = step[39];
    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign pready   = 1'b1;
    assign apb_wr   = psel && penable && pwrite;
    assign mapped   = (paddr == fesq_pkg::OFS_CTRL) ||
                      (paddr == fesq_pkg::OFS_ADDR) ||
                      (paddr == fesq_pkg::OFS_STATUS) ||
                      (paddr == fesq_pkg::OFS_RDATA);
    assign pslverr  = psel && penable && !mapped;
    assign ctrl_wr  = apb_wr && (paddr == fesq_pkg::OFS_CTRL);
    assign op_valid = (pwdata[3:0] >= fesq_pkg::OP_CHIP) &&
                      (pwdata[3:0] <= fesq_pkg::OP_HWRST);
    // A late extra load would land after the device shut the window
    assign win_late = !win_open ||
                      (32'(win_cnt) + fesq_pkg::WIN_MARGIN >= WIN_CYC);
    assign accept   = ctrl_wr && (state == S_IDLE) && op_valid &&
                      !((pwdata[3:0] == fesq_pkg::OP_ADD) && win_late);
    assign reject   = ctrl_wr && !accept;

    always_comb begin
        prdata = 32'h00000000;
        case (paddr)
            fesq_pkg::OFS_CTRL: begin
                prdata[3:0] = op;
            end
            fesq_pkg::OFS_ADDR: begin
                prdata[21:0] = addr;
            end
            fesq_pkg::OFS_STATUS: begin
                prdata[fesq_pkg::ST_BUSY]    = (state != S_IDLE);
                prdata[fesq_pkg::ST_DONE]    = done_flag;
                prdata[fesq_pkg::ST_REFUSED] = refused;
                prdata[fesq_pkg::ST_RDY]     = ready_busy_n; // see [RQ27]
                prdata[fesq_pkg::ST_WINDOW]  = win_open;
            end
            fesq_pkg::OFS_RDATA: begin
                prdata[15:0] = rdata;
            end
            default: begin
                prdata = 32'h00000000;
            end
        endcase
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= fesq_pkg::CTRL_RST;
        end else if (accept) begin
            op <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr <= fesq_pkg::ADDR_RST;
        end else if (apb_wr && (paddr == fesq_pkg::OFS_ADDR) &&
                     (state == S_IDLE)) begin
            addr <= pwdata[21:0];
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
            refused   <= 1'b0;
        end else begin
            if ((state == S_WAIT && cyc_done && last_step &&
                 op != fesq_pkg::OP_POLL) ||
                (state == S_PCHK && poll_done) ||
                (state == S_RWAIT && ready_busy_n)) begin
                done_flag <= 1'b1;
            end else if (accept || (apb_wr &&
                         paddr == fesq_pkg::OFS_STATUS &&
                         pwdata[fesq_pkg::ST_DONE])) begin
                done_flag <= 1'b0;
            end
            if (reject) begin
                refused <= 1'b1;
            end else if (apb_wr && paddr == fesq_pkg::OFS_STATUS &&
                         pwdata[fesq_pkg::ST_REFUSED]) begin
                refused <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    assign cyc_start = (state == S_ISSUE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            idx   <= 3'd0;
        end else begin
            case (state)
                S_IDLE: begin
                    idx <= 3'd0;
                    if (accept) begin
                        state <= (pwdata[3:0] == fesq_pkg::OP_HWRST) ?
                                 S_RST : S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        if (op == fesq_pkg::OP_POLL) begin
                            state <= S_PCHK;
                        end else if (last_step) begin
                            state <= S_IDLE;
                        end else begin
                            idx   <= idx + 3'd1;
                            state <= S_ISSUE;
                        end
                    end
                end
                S_PCHK: begin
                    // Keep reading until two reads agree on completion
                    state <= poll_done ? S_IDLE : S_ISSUE; // see [RQ8]
                end
                S_RST: begin
                    if (rst_cnt >= 8'(fesq_pkg::RP_CYC)) begin
                        state <= S_RWAIT;
                    end
                end
                S_RWAIT: begin
                    if (ready_busy_n) begin
                        state <= S_IDLE; // see [RQ6]
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
    // Reset pulse aborts whatever the device is doing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt       <= 8'h00;
            flash_reset_n <= 1'b1;
        end else begin
            flash_reset_n <= !(state == S_RST &&
                              rst_cnt < 8'(fesq_pkg::RP_CYC)); // see [RQ6]
            rst_cnt <= (state == S_RST) ? rst_cnt + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 16'h0000;
        end else if (state == S_WAIT && cyc_done && !step[38]) begin
            rdata <= cyc_rdata; // see [RQ17]
        end
    end

    // ****************************************************************
    // Sector load window
    // ****************************************************************
    // Counted from the end of each sector write; any other op closes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_open <= 1'b0;
            win_cnt  <= 13'h0000;
        end else if (state == S_WAIT && cyc_done && last_step &&
                     (op == fesq_pkg::OP_SECT ||
                      op == fesq_pkg::OP_ADD)) begin
            win_open <= 1'b1; // see [RQ11]
            win_cnt  <= 13'h0000;
        end else if (accept && pwdata[3:0] != fesq_pkg::OP_ADD) begin
            win_open <= 1'b0;
        end else if (win_open) begin
            if (32'(win_cnt) + 1 >= WIN_CYC) begin
                win_open <= 1'b0;
            end
            win_cnt <= win_cnt + 13'h0001;
        end
    end

    // ****************************************************************
    // Pin cycle engine and completion check
    // ****************************************************************
    fesq_bus_cycle u_cycle (
        .pclk         (pclk),
        .presetn      (presetn),
        .start        (cyc_start),
        .is_write     (step[38]),
        .addr         (step[37:16]),
        .wdata        (step[15:0]),
        .done         (cyc_done),
        .rdata        (cyc_rdata),
        .flash_addr   (flash_addr),
        .flash_dq_out (flash_dq_out),
        .flash_dq_oe  (flash_dq_oe),
        .flash_dq_in  (flash_dq_in),
        .flash_ce_n   (flash_ce_n),
        .flash_we_n   (flash_we_n),
        .flash_oe_n   (flash_oe_n)
    );

    fesq_poll u_poll (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (accept),
        .sample     (state == S_WAIT && cyc_done &&
                     op == fesq_pkg::OP_POLL),
        .poll_bit   (cyc_rdata[fesq_pkg::POLL_BIT]),
        .toggle_bit (cyc_rdata[fesq_pkg::TOGGLE_BIT]),
        .finished   (poll_done)
    );

endmodule : fesq_ctrl

`default_nettype wire

// ===== testbench/fesq_ctrl_monitor.sv
// Checker of the flash pins and the APB answer
`timescale 1ns/1ps
`default_nettype none
module fesq_ctrl_monitor (
    input wire logic pclk, presetn, psel, penable, pready, pslverr,
    input wire logic flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe,
    input wire logic [7:0] paddr,
    input wire logic [21:0] flash_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pready_high: assert property (pready) else $error("pready low");
    a_slverr_map: assert property (psel && penable |->
        pslverr == (paddr[1:0] != 0 || paddr > 8'h0c)) else $error("slverr");
    a_we_ce: assert property (!flash_we_n |-> !flash_ce_n)
        else $error("we without ce");
    a_we_drive: assert property (!flash_we_n |-> flash_dq_oe && flash_oe_n)
        else $error("we not driving");
    a_we_width: assert property ($fell(flash_we_n) |->
        !flash_we_n [*4] ##1 flash_we_n) else $error("we width");
    a_addr_hold: assert property (!flash_ce_n && $past(!flash_ce_n) |->
        $stable(flash_addr)) else $error("addr moved");
    a_ce_gap: assert property ($rose(flash_ce_n) |=> flash_ce_n)
        else $error("ce gap");
    a_dq_free: assert property ($rose(flash_ce_n) |-> !flash_dq_oe)
        else $error("dq held");
endmodule : fesq_ctrl_monitor
bind fesq_ctrl fesq_ctrl_monitor i_fesq_ctrl_monitor (.*);
`default_nettype wire

// ===== testbench/fesq_flash_model.sv
// Behavioural flash answering erase, ID and query sequences
`timescale 1ns/1ps
`default_nettype none
module fesq_flash_model #(
    parameter int ERASE_CYC = 300,
    parameter logic [15:0] MAKER = 16'h005a // Arbitrary maker code
) (
    input wire logic pclk, flash_we_n, flash_oe_n, flash_reset_n,
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    output logic [15:0] flash_dq_in,
    output logic ready_busy_n
);
    int st = 0, ret = 0, cnt = 0;
    logic w = 1, o = 1, h80 = 0, sec = 0, tg = 0;
    logic [15:0] d, v, last = 0;
    assign d = flash_dq_out;
    assign ready_busy_n = st != 1;
    assign v = st == 1 ? {9'h0, tg, 6'h0} :
        st == 3 ? (flash_addr[1:0] == 0 ? MAKER : 16'h0) :
        st != 4 ? 16'hffff : flash_addr == 16 ? 16'h51 :
        flash_addr == 17 ? 16'h52 : 16'h59;
    // Released bus shows the inverse so stale data never passes
    assign flash_dq_in = flash_oe_n ? ~last : v;
    always @(posedge pclk) begin
        w <= flash_we_n;
        o <= flash_oe_n;
        if (!o && flash_oe_n) begin
            last <= v;
            tg <= ~tg;
        end
        if (!flash_reset_n) st <= 0;
        else if (flash_we_n && !w) begin
            if (d == 16'h80) h80 <= 1;
            if (st == 1) begin
                if (d == 16'hb0 && sec) st <= 2;
            end else if (h80 && (d == 16'h10 || d == 16'h30)) begin
                st <= 1;
                cnt <= ERASE_CYC;
                sec <= d[5];
                h80 <= 0;
            end else if (d == 16'h30 && st == 2) st <= 1;
            else if (d == 16'h90) st <= 3;
            else if (d == 16'h98 && st != 4) begin
                ret <= st;
                st <= 4;
            end else if (d == 16'hf0) st <= st == 4 ? ret : 0;
        end else if (st == 1) begin
            cnt <= cnt - 1;
            if (cnt == 0) st <= 0;
        end
    end
endmodule : fesq_flash_model
`default_nettype wire

// ===== testbench/fesq_ctrl_bench.sv
// Self-checking bench of the erase command sequencer
`timescale 1ns/1ps
`default_nettype none
module fesq_ctrl_bench;
    localparam logic [15:0] MAKER = 16'h005a; // Arbitrary maker code
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, er, oe, ce, we, ro, rst, rb;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [21:0] fa;
    logic [15:0] dqo, dqi;
    int n_mismatch = 0, compares = 0, i;
    int unsigned s = 23225;
    always #5 pclk = ~pclk;
    fesq_ctrl #(.WIN_CYC(200)) i_fesq_ctrl (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe(oe),
        .flash_dq_in(dqi), .flash_ce_n(ce), .flash_we_n(we),
        .flash_oe_n(ro), .flash_reset_n(rst), .ready_busy_n(rb));
    fesq_flash_model #(.MAKER(MAKER)) i_fesq_flash_model (.pclk,
        .flash_we_n(we), .flash_oe_n(ro), .flash_reset_n(rst),
        .flash_addr(fa), .flash_dq_out(dqo), .flash_dq_in(dqi),
        .ready_busy_n(rb));
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic op(input logic [3:0] o);
        int k;
        apb(1, 8'h00, {28'h0, o});
        r = 1;
        for (k = 0; k < 5000 && r[0] !== 1'b0; k++) apb(0, 8'h08, 0);
    endtask : op
    task automatic rd(input logic [21:0] a, input logic [15:0] e);
        apb(1, 8'h04, {10'h0, a});
        op(4'h9);
        apb(0, 8'h0c, 0);
        chk("rdata", r, {16'h0, e});
    endtask : rd
    initial begin
        #900000 n_mismatch++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(0, 8'h00, 0);
        chk("ctrl", r, 0);
        apb(0, 8'h10, 0);
        chk("slverr", er, 1);
        op(4'h6);
        rd(0, MAKER);
        op(4'h7);
        for (i = 0; i < 3; i++) rd(16 + i, i == 0 ? 16'h51 : i == 1 ?
            16'h52 : 16'h59);
        op(4'h8);
        rd(0, MAKER);
        op(4'h8);
        s ^= s << 13; s ^= s >> 17; s ^= s << 5;
        rd(s[21:0], 16'hffff);
        $display("id and query test done");
        op(4'h1);
        chk("rb", rb, 0);
        op(4'h4);
        chk("rb", rb, 0);
        op(4'ha);
        apb(0, 8'h08, 0);
        chk("done", r[1], 1);
        op(4'h2);
        op(4'h4);
        chk("rb", rb, 1);
        op(4'h5);
        chk("rb", rb, 0);
        op(4'h4);
        chk("rb", rb, 1);
        op(4'h5);
        op(4'hb);
        chk("rb", rb, 1);
        $display("erase test done");
        give_verdict;
    end
endmodule : fesq_ctrl_bench
`default_nettype wire
